// ==== design/trc_pkg.sv ====
package trc_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_MODULE_ENABLE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RUN_COMMAND = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COMPARE0 = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_COMPARE1 = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_COUNTER_VALUE = 8'h40;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_MODULE_ENABLE = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_RUN_COMMAND = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_CONTROL = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_COMPARE = 32'h0000_0000;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

  // ---------------------------------------------------------------
  // field positions: timer_module_enable
  // ---------------------------------------------------------------
  localparam int BIT_MODULE_CLOCK_ENABLE = 7;
  localparam int BIT_DEBUG_HALT_STOP = 6;

  // ---------------------------------------------------------------
  // field positions: timer_run_command
  // ---------------------------------------------------------------
  localparam int BIT_PRESCALER_RUN = 2;
  localparam int BIT_COUNTER_RUN = 0;

  // ---------------------------------------------------------------
  // field positions: timer_control
  // ---------------------------------------------------------------
  localparam int BIT_DOUBLE_BUFFER_ENABLE = 7;
  localparam int BIT_SYNCHRONOUS_START = 5;
  localparam int BIT_IDLE_OPERATION = 3;
  localparam int BIT_TRIGGER_EDGE_SELECT = 1;
  localparam int BIT_COUNT_START_SELECT = 0;

  // ---------------------------------------------------------------
  // counting defaults
  // ---------------------------------------------------------------
  localparam int CNT_W_DEF = 16;
  localparam int PRE_W_DEF = 8;
  localparam int PRE_DIV_DEF = 2;

endpackage

// ==== design/trc_sync2.sv ====
`timescale 1ns/1ps

module trc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } trc_sync_s;

  trc_sync_s s;
  trc_sync_s next_s;

  // meta is read only by sync, never by other logic
  always_comb begin
    next_s.meta = d;
    next_s.sync = s.meta;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.sync;

endmodule

// ==== design/trc_timer.sv ====
`timescale 1ns/1ps

module trc_timer
  import trc_pkg::*;
#(
  parameter int CNT_W = trc_pkg::CNT_W_DEF,
  parameter int PRE_W = trc_pkg::PRE_W_DEF,
  parameter int PRE_DIV = trc_pkg::PRE_DIV_DEF
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [trc_pkg::ADDR_W-1:0] addr,
  input wire logic [trc_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [trc_pkg::DATA_W-1:0] rdata,
  input wire logic timer_input_pin,
  input wire logic debug_halted,
  input wire logic idle_mode,
  input wire logic sync_start_in,
  output logic [CNT_W-1:0] count_value,
  output logic compare0_match,
  output logic compare1_match,
  output logic counting
);

  import trc_pkg::*;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (CNT_W < 1 || CNT_W > DATA_W) begin : g_bad_cnt_w
    $error("counter width must lie between 1 and the data width");
  end
  if (PRE_DIV < 1 || PRE_DIV > (1 << PRE_W)) begin : g_bad_pre_div
    $error("prescaler divide does not fit the prescaler width");
  end

  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [PRE_W-1:0] PRE_ONE = PRE_W'(1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRE_DIV - 1);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic halt_stop;
    logic prun;
    logic run;
    logic wbf;
    logic sync;
    logic idle_op;
    logic trg_fall;
    logic css;
    logic started;
    logic pin_prev;
    logic [PRE_W-1:0] pre;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] cmp0_buf;
    logic [CNT_W-1:0] cmp1_buf;
    logic [CNT_W-1:0] cmp0;
    logic [CNT_W-1:0] cmp1;
    logic match0;
    logic match1;
    logic [DATA_W-1:0] rdata;
  } trc_state_s;

  trc_state_s s;
  trc_state_s next_s;
  logic rst_sync_b;
  logic pin_s;

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  trc_sync2 #(.WIDTH(1)) u_rst_sync (
    .clock(clock),
    .rst_b(rst_b),
    .d(1'b1),
    .q(rst_sync_b)
  );

  trc_sync2 #(.WIDTH(1)) u_pin_sync (
    .clock(clock),
    .rst_b(rst_sync_b),
    .d(timer_input_pin),
    .q(pin_s)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic clk_on;
  logic tick;
  logic trig_edge;
  logic start_ok;
  logic [DATA_W-1:0] rv;

  always_comb begin
    next_s = s;
    next_s.match0 = 1'b0;
    next_s.match1 = 1'b0;
    next_s.pin_prev = pin_s;
    rv = READ_ZERO;

    clk_on = s.en && !(debug_halted && s.halt_stop) && !(idle_mode && !s.idle_op);
    tick = s.prun && (s.pre == PRE_LAST);
    trig_edge = s.trg_fall ? (s.pin_prev && !pin_s) : (!s.pin_prev && pin_s);
    start_ok = (!s.sync || sync_start_in) && (!s.css || trig_edge);

    if (clk_on) begin
      if (!s.prun || tick) begin
        next_s.pre = '0;
      end else begin
        next_s.pre = s.pre + PRE_ONE;
      end
      if (!s.run) begin
        next_s.cnt = '0;
        next_s.started = 1'b0;
        // a held-clear counter counts as a clear, so buffers load now
        next_s.cmp0 = s.cmp0_buf;
        next_s.cmp1 = s.cmp1_buf;
      end else if (!s.started) begin
        next_s.started = start_ok;
      end else if (tick) begin
        next_s.match0 = (s.cnt == s.cmp0);
        if (s.cnt == s.cmp1) begin
          next_s.match1 = 1'b1;
          next_s.cnt = '0;
          next_s.cmp0 = s.cmp0_buf;
          next_s.cmp1 = s.cmp1_buf;
        end else begin
          next_s.cnt = s.cnt + CNT_ONE;
        end
      end
    end

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    if (wr) begin
      if (addr == OFS_MODULE_ENABLE) begin
        next_s.en = wdata[BIT_MODULE_CLOCK_ENABLE];
        next_s.halt_stop = wdata[BIT_DEBUG_HALT_STOP];
      end else if (s.en) begin
        unique case (addr)
          OFS_RUN_COMMAND: begin
            next_s.prun = wdata[BIT_PRESCALER_RUN];
            next_s.run = wdata[BIT_COUNTER_RUN];
          end
          OFS_CONTROL: begin
            next_s.wbf = wdata[BIT_DOUBLE_BUFFER_ENABLE];
            next_s.sync = wdata[BIT_SYNCHRONOUS_START];
            next_s.idle_op = wdata[BIT_IDLE_OPERATION];
            next_s.trg_fall = wdata[BIT_TRIGGER_EDGE_SELECT];
            next_s.css = wdata[BIT_COUNT_START_SELECT];
          end
          OFS_COMPARE0: begin
            next_s.cmp0_buf = wdata[CNT_W-1:0];
            if (!s.wbf) begin
              next_s.cmp0 = wdata[CNT_W-1:0];
            end
          end
          OFS_COMPARE1: begin
            next_s.cmp1_buf = wdata[CNT_W-1:0];
            if (!s.wbf) begin
              next_s.cmp1 = wdata[CNT_W-1:0];
            end
          end
          default: begin
          end
        endcase
      end
    end

    // ---------------------------------------------------------------
    // register reads
    // ---------------------------------------------------------------
    if (rd) begin
      if (addr == OFS_MODULE_ENABLE) begin
        rv[BIT_MODULE_CLOCK_ENABLE] = s.en;
        rv[BIT_DEBUG_HALT_STOP] = s.halt_stop;
      end else if (s.en) begin
        // disabled or unmapped reads give zero
        unique case (addr)
          OFS_RUN_COMMAND: begin
            rv[BIT_PRESCALER_RUN] = s.prun;
            rv[BIT_COUNTER_RUN] = s.run;
          end
          OFS_CONTROL: begin
            rv[BIT_DOUBLE_BUFFER_ENABLE] = s.wbf;
            rv[BIT_SYNCHRONOUS_START] = s.sync;
            rv[BIT_IDLE_OPERATION] = s.idle_op;
            rv[BIT_TRIGGER_EDGE_SELECT] = s.trg_fall;
            rv[BIT_COUNT_START_SELECT] = s.css;
          end
          OFS_COMPARE0: begin
            rv[CNT_W-1:0] = s.cmp0_buf;
          end
          OFS_COMPARE1: begin
            rv[CNT_W-1:0] = s.cmp1_buf;
          end
          OFS_COUNTER_VALUE: begin
            rv[CNT_W-1:0] = s.cnt;
          end
          default: begin
          end
        endcase
      end
    end
    next_s.rdata = rv;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // only reset clears; disabling leaves values alone
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign count_value = s.cnt;
  assign compare0_match = s.match0;
  assign compare1_match = s.match1;
  assign counting = s.started;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_disabled_read_zero;
    @(posedge clock) disable iff (!rst_sync_b)
    (rd && !s.en && addr != OFS_MODULE_ENABLE) |=> (rdata == READ_ZERO);
  endproperty
  a_disabled_read_zero: assert property (p_disabled_read_zero)
    else $error("read of gated register returned data");

  property p_disabled_write_blocked;
    @(posedge clock) disable iff (!rst_sync_b)
    (wr && !s.en && addr == OFS_RUN_COMMAND) |=> (s.run == $past(s.run) && s.prun == $past(s.prun));
  endproperty
  a_disabled_write_blocked: assert property (p_disabled_write_blocked)
    else $error("write to gated register took effect");

  property p_disable_keeps;
    @(posedge clock) disable iff (!rst_sync_b)
    ($fell(s.en)) |-> ##1 ($stable(s.cnt) && $stable(s.cmp1) && $stable(s.css));
  endproperty
  a_disable_keeps: assert property (p_disable_keeps)
    else $error("registers changed after disable");

  property p_halt_freezes;
    @(posedge clock) disable iff (!rst_sync_b)
    (debug_halted && s.halt_stop) |=> ($stable(s.cnt) && $stable(s.pre));
  endproperty
  a_halt_freezes: assert property (p_halt_freezes)
    else $error("timer moved during debug halt");

  property p_prescaler_clear;
    @(posedge clock) disable iff (!rst_sync_b)
    (clk_on && !s.prun) |=> (s.pre == '0);
  endproperty
  a_prescaler_clear: assert property (p_prescaler_clear)
    else $error("stopped prescaler not cleared");

  property p_counter_clear;
    @(posedge clock) disable iff (!rst_sync_b)
    (clk_on && !s.run) |=> (s.cnt == '0 && !s.started);
  endproperty
  a_counter_clear: assert property (p_counter_clear)
    else $error("stopped counter not cleared");

  property p_sync_waits;
    @(posedge clock) disable iff (!rst_sync_b)
    (s.run && !s.started && s.sync && !sync_start_in) |=> !s.started;
  endproperty
  a_sync_waits: assert property (p_sync_waits)
    else $error("synchronous channel started alone");

  property p_idle_stops;
    @(posedge clock) disable iff (!rst_sync_b)
    (idle_mode && !s.idle_op) |=> ($stable(s.cnt) && $stable(s.started));
  endproperty
  a_idle_stops: assert property (p_idle_stops)
    else $error("timer moved in idle with idle operation off");

  property p_trigger_start;
    @(posedge clock) disable iff (!rst_sync_b)
    (clk_on && s.run && !s.started && s.css && !s.sync && trig_edge) |=> s.started;
  endproperty
  a_trigger_start: assert property (p_trigger_start)
    else $error("selected trigger edge did not start counting");

  property p_trigger_waits;
    @(posedge clock) disable iff (!rst_sync_b)
    (s.run && !s.started && s.css && !trig_edge) |=> !s.started;
  endproperty
  a_trigger_waits: assert property (p_trigger_waits)
    else $error("counting began without the trigger edge");

  property p_direct_compare;
    @(posedge clock) disable iff (!rst_sync_b)
    (wr && s.en && !s.wbf && addr == OFS_COMPARE0) |=> (s.cmp0 == $past(wdata[CNT_W-1:0]));
  endproperty
  a_direct_compare: assert property (p_direct_compare)
    else $error("unbuffered compare write did not take effect");

  property p_buffered_hold;
    @(posedge clock) disable iff (!rst_sync_b)
    (wr && s.en && s.wbf && s.run && addr == OFS_COMPARE1 && !tick) |=> $stable(s.cmp1);
  endproperty
  a_buffered_hold: assert property (p_buffered_hold)
    else $error("buffered compare changed before counter clear");

  property p_unused_zero;
    @(posedge clock) disable iff (!rst_sync_b)
    (rd && (addr == OFS_MODULE_ENABLE || addr == OFS_CONTROL))
      |=> (rdata[DATA_W-1:8] == '0 && rdata[4] == 1'b0 && rdata[2] == 1'b0);
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused bit read as one");

endmodule

// ==== dv/trc_testbench.sv ====
`timescale 1ns/1ps

module testbench;
  import trc_pkg::*;

  // ---------------------------------------------------------------
  // stimulus and observation
  // ---------------------------------------------------------------
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic timer_input_pin = 1'b0;
  logic debug_halted = 1'b0;
  logic idle_mode = 1'b0;
  logic sync_start_in = 1'b0;
  logic [15:0] count_value;
  logic compare0_match;
  logic compare1_match;
  logic counting;
  int fails = 0;
  int n_checks = 0;

  always #5 clock = ~clock;

  // prescaler divide of 1 keeps every run short
  trc_timer #(.CNT_W(16), .PRE_W(8), .PRE_DIV(1)) i_dut (
    .clock(clock),
    .rst_b(rst_b),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .timer_input_pin(timer_input_pin),
    .debug_halted(debug_halted),
    .idle_mode(idle_mode),
    .sync_start_in(sync_start_in),
    .count_value(count_value),
    .compare0_match(compare0_match),
    .compare1_match(compare1_match),
    .counting(counting)
  );

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic conclude();
    if (fails == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    check(rdata, exp);
  endtask

  task automatic wait_counting(input logic lvl);
    bit hit;
    hit = 1'b0;
    for (int i = 0; i < 20 && !hit; i++) begin
      @(negedge clock);
      hit = (counting === lvl);
    end
    if (!hit) begin
      fails++;
      conclude();
    end
  endtask

  // stop first: control may only change while stopped
  task automatic start(input logic [31:0] ctrl);
    bus_wr(OFS_RUN_COMMAND, 32'h0000_0000);
    bus_wr(OFS_CONTROL, ctrl);
    bus_wr(OFS_RUN_COMMAND, 32'h0000_0005);
  endtask

  task automatic motion(input logic exp_moving);
    logic [15:0] c0;
    repeat (2) @(negedge clock);
    c0 = count_value;
    repeat (5) @(negedge clock);
    check({31'h0, count_value !== c0}, {31'h0, exp_moving});
  endtask

  // highest count and compare1 pulses seen over a number of cycles
  task automatic watch(input int cycles, output int mx, output int n1);
    mx = 0;
    n1 = 0;
    repeat (cycles) begin
      @(negedge clock);
      if (int'(count_value) > mx) mx = int'(count_value);
      if (compare1_match === 1'b1) n1++;
    end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_access();
    rd_chk(OFS_MODULE_ENABLE, RST_MODULE_ENABLE);
    bus_wr(OFS_CONTROL, 32'h0000_00ab);
    rd_chk(OFS_CONTROL, 32'h0000_0000);
    bus_wr(OFS_MODULE_ENABLE, 32'hffff_ffff);
    rd_chk(OFS_MODULE_ENABLE, 32'h0000_00c0);
    bus_wr(OFS_CONTROL, 32'hffff_ffff);
    rd_chk(OFS_CONTROL, 32'h0000_00ab);
    bus_wr(OFS_RUN_COMMAND, 32'hffff_ffff);
    rd_chk(OFS_RUN_COMMAND, 32'h0000_0005);
    bus_wr(OFS_RUN_COMMAND, 32'h0000_0000);
    bus_wr(8'h10, 32'hffff_ffff);
    rd_chk(8'h10, 32'h0000_0000);
    bus_wr(OFS_MODULE_ENABLE, 32'h0000_0000);
    rd_chk(OFS_CONTROL, 32'h0000_0000);
    bus_wr(OFS_CONTROL, 32'h0000_0000);
    bus_wr(OFS_MODULE_ENABLE, 32'h0000_0080);
    rd_chk(OFS_CONTROL, 32'h0000_00ab);
    bus_wr(OFS_CONTROL, 32'h0000_0000);
  endtask

  task automatic t_count();
    int mx;
    int n0;
    int n1;
    mx = 0;
    n0 = 0;
    n1 = 0;
    bus_wr(OFS_COMPARE0, 32'h0000_0002);
    bus_wr(OFS_COMPARE1, 32'h0000_0003);
    rd_chk(OFS_COMPARE1, 32'h0000_0003);
    start(32'h0000_0000);
    wait_counting(1'b1);
    check({31'h0, counting}, 32'h0000_0001);
    repeat (30) begin
      @(negedge clock);
      if (int'(count_value) > mx) mx = int'(count_value);
      if (compare0_match === 1'b1) n0++;
      if (compare1_match === 1'b1) n1++;
    end
    check(mx, 32'h0000_0003);
    check({31'h0, n0 >= 3}, 32'h0000_0001);
    check({31'h0, n1 >= 3}, 32'h0000_0001);
    bus_wr(OFS_RUN_COMMAND, 32'h0000_0000);
    repeat (3) @(negedge clock);
    check({16'h0, count_value}, 32'h0000_0000);
    check({31'h0, counting}, 32'h0000_0000);
    rd_chk(OFS_COUNTER_VALUE, 32'h0000_0000);
    bus_wr(OFS_RUN_COMMAND, 32'h0000_0001);
    repeat (10) @(negedge clock);
    check({16'h0, count_value}, 32'h0000_0000);
    bus_wr(OFS_RUN_COMMAND, 32'h0000_0000);
    bus_wr(OFS_COMPARE1, 32'h0000_0100);
  endtask

  task automatic t_halt_idle();
    bus_wr(OFS_MODULE_ENABLE, 32'h0000_00c0);
    start(32'h0000_0000);
    wait_counting(1'b1);
    @(posedge clock);
    debug_halted <= 1'b1;
    motion(1'b0);
    bus_wr(OFS_MODULE_ENABLE, 32'h0000_0080);
    motion(1'b1);
    @(posedge clock);
    debug_halted <= 1'b0;
    start(32'h0000_0000);
    wait_counting(1'b1);
    @(posedge clock);
    idle_mode <= 1'b1;
    motion(1'b0);
    @(posedge clock);
    idle_mode <= 1'b0;
    start(32'h0000_0008);
    wait_counting(1'b1);
    @(posedge clock);
    idle_mode <= 1'b1;
    motion(1'b1);
    @(posedge clock);
    idle_mode <= 1'b0;
  endtask

  // the pin rests at the level opposite the selected edge
  task automatic t_trigger();
    for (int sel = 0; sel < 2; sel++) begin
      bus_wr(OFS_RUN_COMMAND, 32'h0000_0000);
      timer_input_pin <= sel[0];
      repeat (4) @(negedge clock);
      start({30'h0, sel[0], 1'b1});
      repeat (10) @(negedge clock);
      check({31'h0, counting}, 32'h0000_0000);
      @(posedge clock);
      timer_input_pin <= ~sel[0];
      wait_counting(1'b1);
      check({31'h0, counting}, 32'h0000_0001);
    end
  endtask

  task automatic t_sync();
    start(32'h0000_0020);
    repeat (10) @(negedge clock);
    check({31'h0, counting}, 32'h0000_0000);
    @(posedge clock);
    sync_start_in <= 1'b1;
    wait_counting(1'b1);
    check({31'h0, counting}, 32'h0000_0001);
    @(posedge clock);
    sync_start_in <= 1'b0;
  endtask

  // prescaler held so the counter sits at zero while the buffer is written
  task automatic t_buffer();
    int mx;
    int n1;
    bus_wr(OFS_RUN_COMMAND, 32'h0000_0000);
    bus_wr(OFS_CONTROL, 32'h0000_0080);
    bus_wr(OFS_COMPARE1, 32'h0000_0100);
    bus_wr(OFS_RUN_COMMAND, 32'h0000_0001);
    wait_counting(1'b1);
    bus_wr(OFS_COMPARE1, 32'h0000_0003);
    rd_chk(OFS_COMPARE1, 32'h0000_0003);
    bus_wr(OFS_RUN_COMMAND, 32'h0000_0005);
    watch(10, mx, n1);
    check({31'h0, mx > 3}, 32'h0000_0001);
    check(n1, 32'h0000_0000);
    start(32'h0000_0080);
    wait_counting(1'b1);
    watch(30, mx, n1);
    check(mx, 32'h0000_0003);
    check({31'h0, n1 >= 3}, 32'h0000_0001);
    bus_wr(OFS_RUN_COMMAND, 32'h0000_0000);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    t_access();
    t_count();
    t_halt_idle();
    t_trigger();
    t_sync();
    t_buffer();
    conclude();
  end

endmodule
